// [rtl/sib_defines.svh]
`ifndef SIB_DEFINES_SVH
`define SIB_DEFINES_SVH
// timing figures in ns, cycle counts derived at 40 ns
`define SIB_CLK_NS      40
`define SIB_TRP_NS      20
`define SIB_TRCD_NS     20
`define SIB_TWR_NS      15
`define SIB_TRP_CYC     ((`SIB_TRP_NS + `SIB_CLK_NS - 1) / `SIB_CLK_NS)
`define SIB_TRCD_CYC    ((`SIB_TRCD_NS + `SIB_CLK_NS - 1) / `SIB_CLK_NS)
`define SIB_TWR_CYC     ((`SIB_TWR_NS + `SIB_CLK_NS - 1) / `SIB_CLK_NS)
`define SIB_NBANK       4
`define SIB_CAS_LAT     2
`define SIB_BURST_LEN   4
`define SIB_CNT_W       4
`define SIB_CMD_ACT     3'h3
`define SIB_CMD_RD      3'h5
`define SIB_CMD_WR      3'h4
`define SIB_CMD_PRE     3'h2
`define SIB_CMD_BST     3'h6
`define SIB_CMD_NOP     3'h7
`endif

// [rtl/sib_pkg.sv]
package sib_pkg;
   typedef enum logic [2:0] {
      SIB_IDLE   = 3'h0,
      SIB_ACTV   = 3'h1,
      SIB_OPEN   = 3'h3,
      SIB_READ   = 3'h2,
      SIB_WRITE  = 3'h6,
      SIB_RD_AP  = 3'h7,
      SIB_WR_AP  = 3'h5,
      SIB_PRECH  = 3'h4
   } sib_bank_e;
endpackage : sib_pkg

// [rtl/sib_interbank.sv]
`timescale 1ns/1ps
`include "sib_defines.svh"
// What this block does
// - commands decode from CS RAS CAS WE sampled at the clock edge
// - bank is idle once precharged and tRP elapsed
// - bank is row active once opened and tRCD elapsed, no burst
// - read or write state lasts until burst completes or is cut
// - read with auto precharge lasts from READ until tRP elapses
// - write with auto precharge lasts until recovery and precharge done
// - burst terminate affects only the bank currently bursting
// - interrupted auto precharge burst starts its own precharge
// - precharge to another bank leaves a running burst untouched
// - interrupting read takes data bus one CAS latency later
// - interrupting write cuts the read when registered
// - read ends a write when registered; last write data one clock before
// - write ends a write when registered; last data one clock before
// - interrupted read auto precharge begins precharge at that command
// - interrupted write auto precharge: recovery starts at READ, then precharge
// - same for interrupting WRITE, recovery starts at that WRITE
// - chip select high ignores pins; NOP lets activity continue
module sib_interbank (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // command pins
   input  wire logic        CKE,
   input  wire logic        CS_N,
   input  wire logic        RAS_N,
   input  wire logic        CAS_N,
   input  wire logic        WE_N,
   input  wire logic [1:0]  BA,
   input  wire logic        AP,
   // bank status
   output logic [11:0]      BANK_STATE,
   output logic             RD_DATA_EN,
   output logic             WR_DATA_EN,
   output logic [1:0]       DATA_BANK
);
   localparam int NB = `SIB_NBANK;
   localparam int CW = `SIB_CNT_W;
   localparam logic [CW-1:0] TRP  = CW'(`SIB_TRP_CYC);
   localparam logic [CW-1:0] TRCD = CW'(`SIB_TRCD_CYC);
   localparam logic [CW-1:0] TWR  = CW'(`SIB_TWR_CYC);
   localparam logic [CW-1:0] BL   = CW'(`SIB_BURST_LEN);

   logic [2:0] cmd;
   logic       cke_prev_q;
   logic       live;
   logic       new_rd;
   logic       new_wr;
   logic       new_pre;
   logic       new_act;
   logic       new_bst;
   logic       new_burst;
   logic [1:0] burst_bank_q;
   logic       burst_on_q;
   logic [`SIB_CAS_LAT-1:0] rd_pipe_q;
   logic [1:0] rd_bank_pipe_q [`SIB_CAS_LAT];
   logic       wr_on_q;

   // inhibit or nop falls to a non-command code and is ignored
   assign cmd = CS_N ? `SIB_CMD_NOP : {RAS_N, CAS_N, WE_N};

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= CKE;
      end
   end

   // commands only count with clock enable steady high
   assign live    = cke_prev_q && CKE;
   // one strobe per command; every other code acts as no operation
   always_comb begin
      new_rd  = 1'b0;
      new_wr  = 1'b0;
      new_pre = 1'b0;
      new_act = 1'b0;
      new_bst = 1'b0;
      if (live) begin
         case (cmd)
            `SIB_CMD_RD: begin
               new_rd = 1'b1;
            end
            `SIB_CMD_WR: begin
               new_wr = 1'b1;
            end
            `SIB_CMD_PRE: begin
               new_pre = 1'b1;
            end
            `SIB_CMD_ACT: begin
               new_act = 1'b1;
            end
            `SIB_CMD_BST: begin
               new_bst = 1'b1;
            end
            default: begin
               new_rd = 1'b0;
            end
         endcase
      end
   end

   assign new_burst = new_rd || new_wr;

   // which bank owns the column path; a newer burst takes it over
   logic [CW-1:0] burst_cnt_q;
   logic          burst_last;
   assign burst_last = burst_on_q && (burst_cnt_q == '0);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         burst_on_q <= 1'b0;
      end else if (new_burst) begin
         burst_on_q <= 1'b1;
      end else if (new_bst || burst_last) begin
         burst_on_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         burst_bank_q <= 2'h0;
      end else if (new_burst) begin
         burst_bank_q <= BA;
      end
   end

   // beats left; holds once the burst has ended, at zero unless a terminate cut it short
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         burst_cnt_q <= '0;
      end else if (new_burst) begin
         burst_cnt_q <= BL - CW'(1);
      end else if (burst_on_q && !burst_last) begin
         burst_cnt_q <= burst_cnt_q - CW'(1);
      end
   end

   // direction of the running burst; terminate ends either kind
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_on_q <= 1'b0;
      end else if (new_burst) begin
         wr_on_q <= new_wr;
      end else if (new_bst || burst_last) begin
         wr_on_q <= 1'b0;
      end
   end

   // read data leaves CAS latency after the read, whoever was on the bus;
   // a write flushes beats in flight so none reappears after the cut
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rd_pipe_q <= '0;
      end else begin
         rd_pipe_q[0] <= burst_on_q && !wr_on_q && !new_wr;
         for (int i = 1; i < `SIB_CAS_LAT; i++) begin
            rd_pipe_q[i] <= rd_pipe_q[i-1] && !new_wr;
         end
      end
   end

   // bank tag rides along with each read beat
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < `SIB_CAS_LAT; i++) begin
            rd_bank_pipe_q[i] <= 2'h0;
         end
      end else begin
         rd_bank_pipe_q[0] <= burst_bank_q;
         for (int i = 1; i < `SIB_CAS_LAT; i++) begin
            rd_bank_pipe_q[i] <= rd_bank_pipe_q[i-1];
         end
      end
   end

   logic       rd_out;
   logic [1:0] rd_out_bank;
   logic       wr_en_d;
   logic [1:0] data_bank_d;
   assign rd_out      = rd_pipe_q[`SIB_CAS_LAT-1];
   assign rd_out_bank = rd_bank_pipe_q[`SIB_CAS_LAT-1];

   // write data on the new command's clock belongs to the new bank
   always_comb begin
      wr_en_d = new_wr;
      if (wr_on_q && burst_on_q && !burst_last && !new_rd && !new_bst) begin
         wr_en_d = 1'b1;
      end
   end

   // read beats keep their own bank until the new read's beats arrive
   always_comb begin
      if (new_wr) begin
         data_bank_d = BA;
      end else if (rd_out) begin
         data_bank_d = rd_out_bank;
      end else if (new_burst) begin
         data_bank_d = BA;
      end else begin
         data_bank_d = burst_bank_q;
      end
   end

   // a write on this clock silences the read beat
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RD_DATA_EN <= 1'b0;
      end else begin
         RD_DATA_EN <= rd_out && !new_wr;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         WR_DATA_EN <= 1'b0;
      end else begin
         WR_DATA_EN <= wr_en_d;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         DATA_BANK <= 2'h0;
      end else begin
         DATA_BANK <= data_bank_d;
      end
   end

   // each bank drives only its own slice of this net
   wire logic [3*NB-1:0] st_flat;
   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_bank
         sib_pkg::sib_bank_e st_q;
         logic [CW-1:0]      cnt_q;
         logic               hit;
         logic               lost;
         logic               owns;
         assign hit  = (BA == 2'(g));
         assign owns = burst_on_q && (burst_bank_q == 2'(g));
         // another bank's burst steals ours; a precharge does not
         assign lost = new_burst && !hit;

         always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
               st_q  <= sib_pkg::SIB_IDLE;
               cnt_q <= '0;
            end else begin
               case (st_q)
                  sib_pkg::SIB_IDLE: begin
                     if (new_act && hit) begin
                        st_q  <= sib_pkg::SIB_ACTV;
                        cnt_q <= TRCD;
                     end
                  end
                  sib_pkg::SIB_ACTV: begin
                     if (cnt_q <= CW'(1)) begin
                        st_q <= sib_pkg::SIB_OPEN;
                     end else begin
                        cnt_q <= cnt_q - CW'(1);
                     end
                  end
                  sib_pkg::SIB_OPEN: begin
                     if (new_pre && hit) begin
                        st_q  <= sib_pkg::SIB_PRECH;
                        cnt_q <= TRP;
                     end else if (new_burst && hit) begin
                        if (AP) begin
                           st_q  <= new_rd ? sib_pkg::SIB_RD_AP : sib_pkg::SIB_WR_AP;
                           cnt_q <= new_rd ? BL : BL + TWR;
                        end else begin
                           st_q <= new_rd ? sib_pkg::SIB_READ : sib_pkg::SIB_WRITE;
                        end
                     end
                  end
                  sib_pkg::SIB_READ, sib_pkg::SIB_WRITE: begin
                     if (new_pre && hit) begin
                        st_q  <= sib_pkg::SIB_PRECH;
                        cnt_q <= TRP;
                     end else if (new_burst && hit) begin
                        st_q <= new_rd ? sib_pkg::SIB_READ : sib_pkg::SIB_WRITE;
                     end else if (!owns) begin
                        st_q <= sib_pkg::SIB_OPEN;
                     end
                  end
                  sib_pkg::SIB_RD_AP: begin
                     if (lost) begin
                        st_q  <= sib_pkg::SIB_PRECH;
                        cnt_q <= TRP;
                     end else if (cnt_q <= CW'(1)) begin
                        st_q  <= sib_pkg::SIB_PRECH;
                        cnt_q <= TRP;
                     end else begin
                        cnt_q <= cnt_q - CW'(1);
                     end
                  end
                  sib_pkg::SIB_WR_AP: begin
                     if (lost) begin
                        // recovery counted from the interrupting command
                        cnt_q <= TWR;
                     end else if (cnt_q <= CW'(1)) begin
                        st_q  <= sib_pkg::SIB_PRECH;
                        cnt_q <= TRP;
                     end else begin
                        cnt_q <= cnt_q - CW'(1);
                     end
                  end
                  sib_pkg::SIB_PRECH: begin
                     if (cnt_q <= CW'(1)) begin
                        st_q <= sib_pkg::SIB_IDLE;
                     end else begin
                        cnt_q <= cnt_q - CW'(1);
                     end
                  end
                  default: st_q <= sib_pkg::SIB_IDLE;
               endcase
            end
         end

         assign st_flat[3*g +: 3] = st_q;
      end
   endgenerate

   // status leaves a flop, one clock behind the bank state
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         BANK_STATE <= 12'h000;
      end else begin
         BANK_STATE <= st_flat;
      end
   end
endmodule : sib_interbank

// [bench/sib_interbank_sva.sv]
`timescale 1ns/1ps
`include "sib_defines.svh"
module sib_interbank_sva (
   // clock, reset and command pins
   input wire logic        CLK, RST, CKE, CS_N, RAS_N, CAS_N, WE_N, AP,
   input wire logic [1:0]  BA,
   // bank status
   input wire logic [11:0] BANK_STATE,
   input wire logic        RD_DATA_EN, WR_DATA_EN,
   input wire logic [1:0]  DATA_BANK
);
   logic cke_q;
   logic ok;
   logic act;
   logic rd;
   logic wr;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cke_q <= 1'b0;
      end else begin
         cke_q <= CKE;
      end
   end
   // a command counts only with clock enable high on two edges
   assign ok  = cke_q & CKE & ~CS_N;
   assign act = ok & ({RAS_N, CAS_N, WE_N} == `SIB_CMD_ACT);
   assign rd  = ok & ({RAS_N, CAS_N, WE_N} == `SIB_CMD_RD);
   assign wr  = ok & ({RAS_N, CAS_N, WE_N} == `SIB_CMD_WR);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   property p_act_open; act |-> ##2 BANK_STATE[$past(BA, 2)*3 +: 3] == 3'h1; endproperty
   a_act_open: assert property (p_act_open) else $error("activate state");
   property p_wr_start; wr |=> WR_DATA_EN && DATA_BANK == $past(BA); endproperty
   a_wr_start: assert property (p_wr_start) else $error("write start");
   property p_wr_cut; WR_DATA_EN && rd |=> !WR_DATA_EN; endproperty
   a_wr_cut: assert property (p_wr_cut) else $error("write not cut by read");
   property p_rd_cut; RD_DATA_EN && wr |=> !RD_DATA_EN; endproperty
   a_rd_cut: assert property (p_rd_cut) else $error("read not cut by write");
   property p_wr_wr; WR_DATA_EN && wr |=> WR_DATA_EN && DATA_BANK == $past(BA); endproperty
   a_wr_wr: assert property (p_wr_wr) else $error("write handover");
   property p_rd_lat; rd && !RD_DATA_EN && !WR_DATA_EN |-> ##[3:4] RD_DATA_EN; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read latency");
   property p_wrap_pre; BANK_STATE[5:3] == 3'h5 && rd |-> ##[1:6] BANK_STATE[5:3] == 3'h4;
   endproperty
   a_wrap_pre: assert property (p_wrap_pre) else $error("write ap precharge");
   property p_pre_idle; BANK_STATE[5:3] == 3'h4 |-> ##[1:3] BANK_STATE[5:3] == 3'h0;
   endproperty
   a_pre_idle: assert property (p_pre_idle) else $error("precharge to idle");
endmodule : sib_interbank_sva
bind sib_interbank sib_interbank_sva sib_interbank_sva_i (.CLK(CLK), .RST(RST), .CKE(CKE),
   .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .AP(AP), .BA(BA),
   .BANK_STATE(BANK_STATE), .RD_DATA_EN(RD_DATA_EN), .WR_DATA_EN(WR_DATA_EN),
   .DATA_BANK(DATA_BANK));

// [bench/sib_ctrl_model.sv]
`timescale 1ns/1ps
module sib_ctrl_model (
   // clock
   input  wire logic  CLK,
   // command pins
   output logic       CKE, CS_N, RAS_N, CAS_N, WE_N, AP,
   output logic [1:0] BA
);
   initial {CKE, CS_N, RAS_N, CAS_N, WE_N, AP, BA} = 8'hFF;
   // only bank commands and NOP leave here, never refresh or mode load
   // the bench keeps each bank's state apart and judges one bank at a time
   task automatic send(input logic [2:0] c, input logic [1:0] b, input logic a);
      @(posedge CLK);
      {CS_N, RAS_N, CAS_N, WE_N} <= {1'b0, c};
      BA <= b;
      AP <= a;
   endtask : send
   // deselected pins wander so stale values cannot pass for held ones
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge CLK);
         CS_N <= 1'b1;
         {RAS_N, CAS_N, WE_N, BA, AP} <= ~{RAS_N, CAS_N, WE_N, BA, AP};
      end
   endtask : idle
   task automatic clk_en(input logic v);
      @(posedge CLK);
      CKE <= v;
   endtask : clk_en
endmodule : sib_ctrl_model

// [bench/tb_sib_interbank.sv]
`timescale 1ns/1ps
`include "sib_defines.svh"
module tb_sib_interbank;
   logic        clk, rst, cke, cs_n, ras_n, cas_n, we_n, ap, rd_en, wr_en;
   logic [1:0]  ba, dbank;
   logic [11:0] bst;
   int          error_cnt, compares;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   sib_ctrl_model sib_ctrl_model_i (.CLK(clk), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
      .CAS_N(cas_n), .WE_N(we_n), .AP(ap), .BA(ba));
   sib_interbank sib_interbank_i (.CLK(clk), .RST(rst), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
      .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .AP(ap), .BANK_STATE(bst), .RD_DATA_EN(rd_en),
      .WR_DATA_EN(wr_en), .DATA_BANK(dbank));
   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic a);
      sib_ctrl_model_i.send(c, b, a);
   endtask : cmd
   task automatic nop(input int k);
      sib_ctrl_model_i.idle(k);
   endtask : nop
   task automatic tally_and_finish;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wst(input int b, input logic [2:0] v);
      int k;
      #1;
      for (k = 0; k < 16 && bst[b*3 +: 3] !== v; k++) @(posedge clk) #1;
      chk("bank state", 12'(v), 12'(bst[b*3 +: 3]));
      if (k == 16) tally_and_finish();
   endtask : wst
   // waits for a data run, then measures its length and final owner
   task automatic run(input logic r, input logic [1:0] b, input int len);
      int k;
      int n;
      logic [1:0] o;
      #1;
      for (k = 0; k < 16 && (r ? rd_en : wr_en) !== 1'b1; k++) @(posedge clk) #1;
      for (n = 0; n < 16 && (r ? rd_en : wr_en) === 1'b1; n++) begin
         o = dbank;
         @(posedge clk) #1;
      end
      chk("run length", 12'(len), 12'(n));
      chk("data bank", 12'(b), 12'(o));
      if (k == 16) tally_and_finish();
   endtask : run
   task automatic s_read;
      cmd(`SIB_CMD_ACT, 2'h1, 1'b0);
      nop(1);
      wst(1, 3'h1);
      wst(1, 3'h3);
      cmd(`SIB_CMD_RD, 2'h1, 1'b0);
      nop(1);
      run(1'b1, 2'h1, 4);
      wst(1, 3'h3);
   endtask : s_read
   task automatic s_wr_wr;
      cmd(`SIB_CMD_ACT, 2'h2, 1'b0);
      nop(1);
      wst(2, 3'h3);
      fork
         run(1'b0, 2'h2, 6);
         begin
            cmd(`SIB_CMD_WR, 2'h1, 1'b0);
            nop(1);
            cmd(`SIB_CMD_WR, 2'h2, 1'b0);
            nop(1);
         end
      join
   endtask : s_wr_wr
   task automatic s_rd_wr;
      int k;
      cmd(`SIB_CMD_RD, 2'h1, 1'b0);
      nop(1);
      for (k = 0; k < 16 && rd_en !== 1'b1; k++) @(posedge clk) #1;
      chk("read data", 12'h1, 12'(rd_en));
      if (k == 16) tally_and_finish();
      // no data mask pin here, so only the cut and the write run are judged
      cmd(`SIB_CMD_WR, 2'h2, 1'b0);
      nop(1);
      fork
         run(1'b0, 2'h2, 4);
         begin
            #1;
            chk("read cut", 12'h0, 12'(rd_en));
            @(posedge clk) #1;
            chk("read cut", 12'h0, 12'(rd_en));
         end
      join
   endtask : s_rd_wr
   task automatic s_wrap_rd;
      cmd(`SIB_CMD_WR, 2'h1, 1'b1);
      nop(1);
      cmd(`SIB_CMD_RD, 2'h2, 1'b0);
      nop(1);
      fork
         run(1'b1, 2'h2, 4);
         begin
            wst(1, 3'h4);
            wst(1, 3'h0);
         end
      join
   endtask : s_wrap_rd
   task automatic s_rdap_pre;
      cmd(`SIB_CMD_RD, 2'h2, 1'b1);
      cmd(`SIB_CMD_PRE, 2'h3, 1'b0);
      nop(1);
      fork
         run(1'b1, 2'h2, 4);
         wst(2, 3'h0);
      join
   endtask : s_rdap_pre
   task automatic s_ignore;
      sib_ctrl_model_i.clk_en(1'b0);
      cmd(`SIB_CMD_ACT, 2'h0, 1'b0);
      sib_ctrl_model_i.clk_en(1'b1);
      nop(6);
      chk("gated bank", 12'h0, 12'(bst[2:0]));
   endtask : s_ignore
   initial begin
      error_cnt = 0;
      compares = 0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      nop(2);
      s_read();
      s_wr_wr();
      s_rd_wr();
      s_wrap_rd();
      s_rdap_pre();
      s_ignore();
      tally_and_finish();
   end
endmodule : tb_sib_interbank
